// ===== ohlc_defines.svh
// Offsets, field positions and reset values for the list control block
`ifndef OHLC_DEFINES_SVH
`define OHLC_DEFINES_SVH

// Register offsets within the base address region
`define OHLC_LIST_CTRL_OFS     8'h04
`define OHLC_CMD_STATUS_OFS    8'h08

// List control field positions
`define OHLC_RATIO_LSB         0
`define OHLC_RATIO_MSB         1
`define OHLC_PER_EN_BIT        2
`define OHLC_ISO_EN_BIT        3
`define OHLC_CLE_BIT           4

// Command/status field positions
`define OHLC_CMD_LSB           0
`define OHLC_CMD_MSB           3
`define OHLC_SOC_LSB           16
`define OHLC_SOC_MSB           17

// Reset values
`define OHLC_LIST_CTRL_RST     5'h00
`define OHLC_CMD_RST           4'h0
`define OHLC_SOC_RST           2'h0
`define OHLC_COUNT_RST         3'h0
`define OHLC_RDATA_RST         32'h0000_0000

`endif

// ===== ohlc_list_control.sv
// List control and command/status registers with frame list sequencing
`timescale 1ns/1ps
`include "ohlc_defines.svh"

// Summary of operation
// - Control list runs from next frame once enabled; stops at once when cleared.
// - Control enable is sampled before each control list step; zero skips it.
// - Isochronous ED with iso enable clear abandons periodic list for non-periodic.
// - Iso enable changes take effect from the following frame only.
// - Periodic enable is checked at frame start before the periodic list.
// - Ratio field codes 00b, 01b, 10b give 1:1, 2:1, 3:1.
// - Each non-periodic step compares ratio with served count, then picks list.
// - Control service count survives frame boundaries; never cleared at SOF.
// - Command/status at 08h is write-one-to-set; zeros leave bits alone.
// - All command/status bits read back their current value.
// - Periodic list unfinished at EOF flags overrun, bumps count, sets flag.
// - Two-bit overrun count starts at 00b, wraps after 11b, counts every overrun.
module ohlc_list_control #(
  parameter int COUNT_W = 3
) (
  // Clock and reset
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESET_IN,
  input  wire logic        SOFT_RESET_IN,
  // Register port
  input  wire logic        REG_WR_IN,
  input  wire logic        REG_RD_IN,
  input  wire logic [7:0]  REG_ADDR_IN,
  input  wire logic [31:0] REG_WDATA_IN,
  output logic      [31:0] REG_RDATA_OUT,
  output logic             REG_RVALID_OUT,
  // Frame and list walker events
  input  wire logic        SOF_IN,
  input  wire logic        EOF_IN,
  input  wire logic        ISO_ED_SEEN_IN,
  input  wire logic        PERIODIC_DONE_IN,
  input  wire logic        NP_STEP_REQ_IN,
  input  wire logic        CTRL_ED_NONEMPTY_IN,
  input  wire logic        BULK_READY_IN,
  input  wire logic [3:0]  CMD_CLEAR_IN,
  // Scheduler decisions
  output logic             PERIODIC_GO_OUT,
  output logic             ISO_CONTINUE_OUT,
  output logic             ISO_ABORT_OUT,
  output logic             SERVE_CTRL_OUT,
  output logic             SERVE_BULK_OUT,
  output logic             OVERRUN_SET_OUT,
  output logic [3:0]       CMD_BITS_OUT
);

  // Register state
  logic [4:0]  list_ctrl_reg;
  logic [4:0]  list_ctrl_next;
  logic [3:0]  cmd_reg;
  logic [3:0]  cmd_next;
  logic [1:0]  soc_reg;
  logic [1:0]  soc_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        rvalid_reg;
  logic        rvalid_next;
  // Frame state
  ohlc_pkg::ohlc_phase_t phase_reg;
  ohlc_pkg::ohlc_phase_t phase_next;
  logic        iso_frame_reg;
  logic        iso_frame_next;
  logic        cle_frame_reg;
  logic        cle_frame_next;
  logic        pgo_reg;
  logic        pgo_next;
  logic        icont_reg;
  logic        icont_next;
  logic        iabort_reg;
  logic        iabort_next;
  logic        ovr_reg;
  logic        ovr_next;
  // Decoded views
  logic        wr_ctrl;
  logic        wr_cmd;
  logic        cle_live;
  logic        per_live;
  logic        overrun;
  logic        ctrl_en;
  logic        np_step;
  logic [31:0] ctrl_view;
  logic [31:0] cmd_view;

  // Address decode
  assign wr_ctrl  = REG_WR_IN && (REG_ADDR_IN == `OHLC_LIST_CTRL_OFS);
  assign wr_cmd   = REG_WR_IN && (REG_ADDR_IN == `OHLC_CMD_STATUS_OFS);
  assign cle_live = list_ctrl_reg[`OHLC_CLE_BIT];
  assign per_live = list_ctrl_reg[`OHLC_PER_EN_BIT];

  // Readback images; reserved bits read as zero
  always_comb begin
    ctrl_view = 32'h0000_0000;
    ctrl_view[`OHLC_CLE_BIT:`OHLC_RATIO_LSB] = list_ctrl_reg;
    cmd_view  = 32'h0000_0000;
    cmd_view[`OHLC_CMD_MSB:`OHLC_CMD_LSB] = cmd_reg;
    cmd_view[`OHLC_SOC_MSB:`OHLC_SOC_LSB] = soc_reg;
  end

  // Overrun: periodic list still running when the frame ends
  // overrun at EOF
  assign overrun = EOF_IN && (phase_reg == ohlc_pkg::ST_PERIODIC);

  // Register next values
  always_comb begin
    list_ctrl_next = list_ctrl_reg;
    cmd_next       = cmd_reg & ~CMD_CLEAR_IN;
    soc_next       = soc_reg;
    rvalid_next    = REG_RD_IN;
    rdata_next     = `OHLC_RDATA_RST;
    // Driver owns the ratio after a reset; hardware only clears it
    // ratio restored by software
    if (wr_ctrl) begin
      list_ctrl_next = REG_WDATA_IN[`OHLC_CLE_BIT:`OHLC_RATIO_LSB];
    end
    // Ones set, zeros keep; set beats a same-cycle clear
    // write one to set
    if (wr_cmd) begin
      cmd_next = cmd_next | REG_WDATA_IN[`OHLC_CMD_MSB:`OHLC_CMD_LSB];
    end
    // Count every overrun, wrapping naturally
    // overrun count wraps
    if (overrun) begin
      soc_next = soc_reg + 2'h1;
    end
    if (REG_RD_IN) begin
      case (REG_ADDR_IN)
        `OHLC_LIST_CTRL_OFS:  rdata_next = ctrl_view;
        `OHLC_CMD_STATUS_OFS: rdata_next = cmd_view;
        default:              rdata_next = `OHLC_RDATA_RST;
      endcase
    end
    if (SOFT_RESET_IN) begin
      list_ctrl_next = `OHLC_LIST_CTRL_RST;
      cmd_next       = `OHLC_CMD_RST;
      soc_next       = `OHLC_SOC_RST;
    end
  end

  // Register flops
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      list_ctrl_reg <= `OHLC_LIST_CTRL_RST;
      cmd_reg       <= `OHLC_CMD_RST;
      soc_reg       <= `OHLC_SOC_RST;
      rdata_reg     <= `OHLC_RDATA_RST;
      rvalid_reg    <= 1'b0;
    end else begin
      list_ctrl_reg <= list_ctrl_next;
      cmd_reg       <= cmd_next;
      soc_reg       <= soc_next;
      rdata_reg     <= rdata_next;
      rvalid_reg    <= rvalid_next;
    end
  end

  // Frame phase sequencing and per-frame enable snapshots
  always_comb begin
    phase_next     = phase_reg;
    iso_frame_next = iso_frame_reg;
    cle_frame_next = cle_frame_reg;
    pgo_next       = 1'b0;
    icont_next     = 1'b0;
    iabort_next    = 1'b0;
    ovr_next       = overrun;
    if (SOF_IN) begin
      iso_frame_next = list_ctrl_reg[`OHLC_ISO_EN_BIT];
      cle_frame_next = cle_live;
      if (per_live) begin
        phase_next = ohlc_pkg::ST_PERIODIC;
        pgo_next   = 1'b1;
      end else begin
        phase_next = ohlc_pkg::ST_NONPER;
      end
    end else begin
      case (phase_reg)
        ohlc_pkg::ST_IDLE: begin
          phase_next = ohlc_pkg::ST_IDLE;
        end
        ohlc_pkg::ST_PERIODIC: begin
          if (EOF_IN) begin
            phase_next = ohlc_pkg::ST_IDLE;
          end else if (ISO_ED_SEEN_IN) begin
            if (iso_frame_reg) begin
              icont_next = 1'b1;
            end else begin
              iabort_next = 1'b1;
              phase_next  = ohlc_pkg::ST_NONPER;
            end
          end else if (PERIODIC_DONE_IN) begin
            phase_next = ohlc_pkg::ST_NONPER;
          end
        end
        ohlc_pkg::ST_NONPER: begin
          if (EOF_IN) begin
            phase_next = ohlc_pkg::ST_IDLE;
          end
        end
        default: begin
          phase_next = ohlc_pkg::ST_IDLE;
        end
      endcase
    end
    // Clearing the enable drops this frame's grant; a re-set waits for SOF
    // set acts next frame
    if (!cle_live) begin
      cle_frame_next = 1'b0;
    end
    if (SOFT_RESET_IN) begin
      phase_next     = ohlc_pkg::ST_IDLE;
      iso_frame_next = 1'b0;
      cle_frame_next = 1'b0;
      pgo_next       = 1'b0;
      icont_next     = 1'b0;
      iabort_next    = 1'b0;
    end
  end

  // Frame state flops
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      phase_reg     <= ohlc_pkg::ST_IDLE;
      iso_frame_reg <= 1'b0;
      cle_frame_reg <= 1'b0;
      pgo_reg       <= 1'b0;
      icont_reg     <= 1'b0;
      iabort_reg    <= 1'b0;
      ovr_reg       <= 1'b0;
    end else begin
      phase_reg     <= phase_next;
      iso_frame_reg <= iso_frame_next;
      cle_frame_reg <= cle_frame_next;
      pgo_reg       <= pgo_next;
      icont_reg     <= icont_next;
      iabort_reg    <= iabort_next;
      ovr_reg       <= ovr_next;
    end
  end

  // Control list allowed only if enabled this frame and still enabled now
  // live enable sampled
  assign ctrl_en = cle_live && cle_frame_reg;
  assign np_step = NP_STEP_REQ_IN && (phase_reg == ohlc_pkg::ST_NONPER) && !SOF_IN && !EOF_IN;

  // Control versus bulk arbitration
  ohlc_np_arbiter #(
    .COUNT_W (COUNT_W)
  ) u_arb (
    .clk_in           (SYS_CLK_IN),
    .rst_in           (RESET_IN),
    .soft_rst_in      (SOFT_RESET_IN),
    .step_req_in      (np_step),
    .ctrl_en_in       (ctrl_en),
    .bulk_ready_in    (BULK_READY_IN),
    .ratio_in         (list_ctrl_reg[`OHLC_RATIO_MSB:`OHLC_RATIO_LSB]),
    .ctrl_nonempty_in (CTRL_ED_NONEMPTY_IN),
    .serve_ctrl_out   (SERVE_CTRL_OUT),
    .serve_bulk_out   (SERVE_BULK_OUT),
    .ctrl_count_out   ()
  );

  // Outputs straight from flops
  assign REG_RDATA_OUT    = rdata_reg;
  assign REG_RVALID_OUT   = rvalid_reg;
  assign PERIODIC_GO_OUT  = pgo_reg;
  assign ISO_CONTINUE_OUT = icont_reg;
  assign ISO_ABORT_OUT    = iabort_reg;
  assign OVERRUN_SET_OUT  = ovr_reg;
  assign CMD_BITS_OUT     = cmd_reg;

endmodule : ohlc_list_control

// ===== ohlc_list_control_bench.sv
// Self-checking bench for the list control block
`timescale 1ns/1ps
module ohlc_list_control_bench;
  localparam logic [5:0] SOF = 6'h01, EOF = 6'h02, ISO = 6'h04, PDN = 6'h08, STP = 6'h10, NEM = 6'h20;
  localparam logic [5:0] GO = 6'h20, CON = 6'h10, ABT = 6'h08, CTL = 6'h04, BLK = 6'h02, OVR = 6'h01;
  logic        SYS_CLK_IN, RESET_IN, SOFT_RESET_IN, REG_WR_IN, REG_RD_IN, BULK_READY_IN;
  logic        SOF_IN, EOF_IN, ISO_ED_SEEN_IN, PERIODIC_DONE_IN, NP_STEP_REQ_IN, CTRL_ED_NONEMPTY_IN;
  logic        REG_RVALID_OUT, PERIODIC_GO_OUT, ISO_CONTINUE_OUT, ISO_ABORT_OUT;
  logic        SERVE_CTRL_OUT, SERVE_BULK_OUT, OVERRUN_SET_OUT;
  logic [7:0]  REG_ADDR_IN;
  logic [31:0] REG_WDATA_IN, REG_RDATA_OUT;
  logic [3:0]  CMD_CLEAR_IN, CMD_BITS_OUT;
  logic [5:0]  ev, dec;
  int          error_cnt, num_checks, cyc;
  // Event pulses and decisions as vectors
  assign {CTRL_ED_NONEMPTY_IN, NP_STEP_REQ_IN, PERIODIC_DONE_IN, ISO_ED_SEEN_IN, EOF_IN, SOF_IN} = ev;
  assign dec = {PERIODIC_GO_OUT, ISO_CONTINUE_OUT, ISO_ABORT_OUT, SERVE_CTRL_OUT, SERVE_BULK_OUT, OVERRUN_SET_OUT};
  ohlc_list_control #(.COUNT_W(3)) uut (.*);
  // Clock
  initial begin
    SYS_CLK_IN = 1'b0;
    forever #25 SYS_CLK_IN = ~SYS_CLK_IN;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic pulse(input logic [5:0] m);
    @(posedge SYS_CLK_IN) ev <= m;
    @(posedge SYS_CLK_IN) ev <= 6'h00;
    #1;
  endtask : pulse
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK_IN) {REG_WR_IN, REG_ADDR_IN, REG_WDATA_IN} <= {1'b1, a, d};
    @(posedge SYS_CLK_IN) REG_WR_IN <= 1'b0;
  endtask : wr
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge SYS_CLK_IN) {REG_RD_IN, REG_ADDR_IN} <= {1'b1, a};
    @(posedge SYS_CLK_IN) REG_RD_IN <= 1'b0;
    #1;
    chk(32'(REG_RVALID_OUT), 32'h0000_0001);
    chk(REG_RDATA_OUT, exp);
  endtask : rdc
  task automatic step_chk(input logic [5:0] exp);
    pulse(STP);
    chk(32'(dec), 32'(exp));
  endtask : step_chk
  task automatic t_reset;
    rdc(8'h04, 32'h0000_0000);
    rdc(8'h08, 32'h0000_0000);
    rdc(8'h10, 32'h0000_0000);
  endtask : t_reset
  task automatic t_cmd;
    wr(8'h08, 32'h0000_0005);
    rdc(8'h08, 32'h0000_0005);
    wr(8'h08, 32'h0000_0002);
    rdc(8'h08, 32'h0000_0007);
    wr(8'h08, 32'hFFFF_FFFF);
    rdc(8'h08, 32'h0000_000F);
    @(posedge SYS_CLK_IN) {REG_WR_IN, REG_ADDR_IN, REG_WDATA_IN, CMD_CLEAR_IN} <= {1'b1, 8'h08, 32'h0000_0001, 4'hF};
    @(posedge SYS_CLK_IN) REG_WR_IN <= 1'b0;
    #1;
    chk(32'(CMD_BITS_OUT), 32'h0000_0001);
    @(posedge SYS_CLK_IN) CMD_CLEAR_IN <= 4'hF;
    @(posedge SYS_CLK_IN) CMD_CLEAR_IN <= 4'h0;
    #1;
    chk(32'(CMD_BITS_OUT), 32'h0000_0000);
  endtask : t_cmd
  task automatic t_iso;
    wr(8'h04, 32'h0000_0014);
    pulse(SOF);
    chk(32'(dec), 32'(GO));
    wr(8'h04, 32'h0000_001C);
    pulse(ISO);
    chk(32'(dec), 32'(ABT));
    pulse(EOF);
    pulse(SOF);
    pulse(ISO);
    chk(32'(dec), 32'(CON));
    pulse(PDN);
    pulse(EOF);
    chk(32'(dec), 32'h0000_0000);
    wr(8'h04, 32'h0000_0018);
    pulse(SOF);
    chk(32'(dec), 32'h0000_0000);
    pulse(EOF);
  endtask : t_iso
  task automatic t_overrun;
    wr(8'h04, 32'h0000_0004);
    for (int i = 1; i <= 5; i++) begin
      pulse(SOF);
      pulse(EOF);
      chk(32'(dec), 32'(OVR));
      rdc(8'h08, 32'(i % 4) << 16);
    end
  endtask : t_overrun
  task automatic t_ratio;
    for (int r = 0; r < 4; r++) begin
      wr(8'h04, 32'h0000_0014 | 32'(r));
      pulse(SOF);
      pulse(PDN);
      for (int k = 0; k <= r; k++) begin
        step_chk(CTL);
        pulse(NEM);
      end
      step_chk(BLK);
      pulse(EOF);
    end
  endtask : t_ratio
  task automatic t_keep;
    wr(8'h04, 32'h0000_0015);
    pulse(SOF);
    pulse(PDN);
    step_chk(CTL);
    pulse(NEM);
    pulse(EOF);
    pulse(SOF);
    pulse(PDN);
    step_chk(CTL);
    pulse(NEM);
    step_chk(BLK);
    pulse(EOF);
  endtask : t_keep
  task automatic t_enable;
    pulse(SOF);
    pulse(PDN);
    wr(8'h04, 32'h0000_0004);
    @(posedge SYS_CLK_IN) BULK_READY_IN <= 1'b0;
    step_chk(6'h00);
    wr(8'h04, 32'h0000_0014);
    step_chk(6'h00);
    pulse(EOF);
    pulse(SOF);
    pulse(PDN);
    step_chk(CTL);
    pulse(EOF);
    @(posedge SYS_CLK_IN) BULK_READY_IN <= 1'b1;
  endtask : t_enable
  task automatic t_soft;
    wr(8'h04, 32'h0000_001F);
    @(posedge SYS_CLK_IN) SOFT_RESET_IN <= 1'b1;
    @(posedge SYS_CLK_IN) SOFT_RESET_IN <= 1'b0;
    rdc(8'h04, 32'h0000_0000);
    rdc(8'h08, 32'h0000_0000);
    wr(8'h04, 32'h0000_0001);
    rdc(8'h04, 32'h0000_0001);
  endtask : t_soft
  task automatic end_of_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : end_of_test
  // Hang guard
  always @(posedge SYS_CLK_IN) begin
    cyc++;
    if (cyc > 5000) begin
      error_cnt++;
      end_of_test();
    end
  end
  // Main sequence
  initial begin
    {RESET_IN, SOFT_RESET_IN, REG_WR_IN, REG_RD_IN, BULK_READY_IN} = 5'h11;
    {REG_ADDR_IN, REG_WDATA_IN, CMD_CLEAR_IN, ev} = '0;
    repeat (16) @(posedge SYS_CLK_IN);
    RESET_IN <= 1'b0;
    t_reset();
    t_cmd();
    t_iso();
    t_overrun();
    t_ratio();
    t_keep();
    t_enable();
    t_soft();
    end_of_test();
  end
endmodule : ohlc_list_control_bench

// ===== ohlc_list_control_sva.sv
// Port checker for the list control block
`timescale 1ns/1ps
module ohlc_list_control_sva (
  // Clock, reset and register port
  input wire logic        SYS_CLK_IN, RESET_IN, SOFT_RESET_IN, REG_WR_IN, REG_RD_IN,
  input wire logic [7:0]  REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN, REG_RDATA_OUT,
  input wire logic        REG_RVALID_OUT,
  // Frame events and decisions
  input wire logic        SOF_IN, EOF_IN, ISO_ED_SEEN_IN, PERIODIC_DONE_IN, NP_STEP_REQ_IN,
  input wire logic        CTRL_ED_NONEMPTY_IN, BULK_READY_IN, PERIODIC_GO_OUT, OVERRUN_SET_OUT,
  input wire logic        ISO_CONTINUE_OUT, ISO_ABORT_OUT, SERVE_CTRL_OUT, SERVE_BULK_OUT,
  input wire logic [3:0]  CMD_CLEAR_IN, CMD_BITS_OUT
);
  logic [4:0] ctl_reg, ctl_next;
  logic       iso_reg, iso_next, per_live, cle_live, wr_cmd;
  logic [3:0] wcmd;
  // Decoded helpers
  assign per_live = ctl_reg[2];
  assign cle_live = ctl_reg[4];
  assign wcmd = REG_WDATA_IN[3:0];
  assign wr_cmd = REG_WR_IN && REG_ADDR_IN == 8'h08;
  // Shadow of list control and frame iso snapshot
  always_comb begin
    ctl_next = ctl_reg;
    iso_next = iso_reg;
    if (REG_WR_IN && REG_ADDR_IN == 8'h04)
      ctl_next = REG_WDATA_IN[4:0];
    if (SOF_IN)
      iso_next = ctl_reg[3];
    if (SOFT_RESET_IN) begin
      ctl_next = 5'h00;
      iso_next = 1'b0;
    end
  end
  // Shadow registers
  always_ff @(posedge SYS_CLK_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      ctl_reg <= 5'h00;
      iso_reg <= 1'b0;
    end else begin
      ctl_reg <= ctl_next;
      iso_reg <= iso_next;
    end
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (RESET_IN);
  rvalid_pulse_a: assert property (REG_RVALID_OUT == $past(REG_RD_IN))
    else $error("read valid not one cycle after read");
  unmapped_read_a: assert property (REG_RD_IN && REG_ADDR_IN != 8'h04 && REG_ADDR_IN != 8'h08
    |=> REG_RDATA_OUT == 32'h0000_0000) else $error("unmapped read not zero");
  cmd_set_a: assert property (wr_cmd && CMD_CLEAR_IN == 4'h0 && !SOFT_RESET_IN
    |=> CMD_BITS_OUT == ($past(CMD_BITS_OUT) | $past(wcmd))) else $error("command write not set-only");
  cmd_keep_a: assert property (!wr_cmd && CMD_CLEAR_IN == 4'h0 && !SOFT_RESET_IN
    |=> $stable(CMD_BITS_OUT)) else $error("command bits changed without cause");
  cmd_read_a: assert property (REG_RD_IN && REG_ADDR_IN == 8'h08 && !REG_WR_IN
    |=> REG_RDATA_OUT[3:0] == $past(CMD_BITS_OUT) && REG_RDATA_OUT[15:4] == 12'h000)
    else $error("command read wrong");
  periodic_go_a: assert property (SOF_IN && !SOFT_RESET_IN
    |=> PERIODIC_GO_OUT == $past(per_live)) else $error("periodic start wrong");
  periodic_only_a: assert property (!SOF_IN |=> !PERIODIC_GO_OUT)
    else $error("periodic start without frame");
  iso_abort_a: assert property (ISO_ABORT_OUT |-> $past(ISO_ED_SEEN_IN) && !$past(iso_reg))
    else $error("iso abort wrong");
  iso_go_a: assert property (ISO_CONTINUE_OUT |-> $past(ISO_ED_SEEN_IN) && $past(iso_reg))
    else $error("iso continue wrong");
  overrun_cause_a: assert property (OVERRUN_SET_OUT |-> $past(EOF_IN))
    else $error("overrun without end of frame");
  serve_cause_a: assert property (SERVE_CTRL_OUT || SERVE_BULK_OUT
    |-> $past(NP_STEP_REQ_IN) && !(SERVE_CTRL_OUT && SERVE_BULK_OUT)) else $error("serve wrong");
  bulk_ready_a: assert property (SERVE_BULK_OUT |-> $past(BULK_READY_IN))
    else $error("bulk served while not ready");
  ctrl_enable_a: assert property (SERVE_CTRL_OUT |-> $past(cle_live))
    else $error("control served while disabled");
endmodule : ohlc_list_control_sva

bind ohlc_list_control ohlc_list_control_sva chk_i (.*);

// ===== ohlc_np_arbiter.sv
// Control versus bulk choice for each non-periodic list step
`timescale 1ns/1ps
`include "ohlc_defines.svh"

module ohlc_np_arbiter #(
  parameter int COUNT_W = 3
) (
  // Clock and reset
  input  wire logic                 clk_in,
  input  wire logic                 rst_in,
  input  wire logic                 soft_rst_in,
  // Step request and qualifiers
  input  wire logic                 step_req_in,
  input  wire logic                 ctrl_en_in,
  input  wire logic                 bulk_ready_in,
  input  wire ohlc_pkg::ohlc_ratio_t ratio_in,
  input  wire logic                 ctrl_nonempty_in,
  // Decisions
  output logic                      serve_ctrl_out,
  output logic                      serve_bulk_out,
  output logic [COUNT_W-1:0]        ctrl_count_out
);

  // Count must hold the largest limit of four
  if (COUNT_W < 3) begin : g_count_w_check
    $error("COUNT_W must be at least 3");
  end

  // Control EDs allowed per bulk ED for a ratio code
  function automatic logic [COUNT_W-1:0] ratio_limit(input ohlc_pkg::ohlc_ratio_t r);
    ratio_limit = COUNT_W'({1'b0, r}) + COUNT_W'(1);
  endfunction : ratio_limit

  logic               serve_ctrl_reg;
  logic               serve_ctrl_next;
  logic               serve_bulk_reg;
  logic               serve_bulk_next;
  logic [COUNT_W-1:0] count_reg;
  logic [COUNT_W-1:0] count_next;
  logic [COUNT_W-1:0] limit;

  assign limit = ratio_limit(ratio_in);

  // Next decision and service count
  always_comb begin
    serve_ctrl_next = 1'b0;
    serve_bulk_next = 1'b0;
    count_next      = count_reg;
    if (ctrl_nonempty_in && (count_reg < limit)) begin
      count_next = count_reg + COUNT_W'(1);
    end
    if (step_req_in) begin
      if (ctrl_en_in && ((count_reg < limit) || !bulk_ready_in)) begin
        serve_ctrl_next = 1'b1;
      end else if (bulk_ready_in) begin
        serve_bulk_next = 1'b1;
        count_next      = COUNT_W'(`OHLC_COUNT_RST);
      end
    end
    if (soft_rst_in) begin
      count_next      = COUNT_W'(`OHLC_COUNT_RST);
      serve_ctrl_next = 1'b0;
      serve_bulk_next = 1'b0;
    end
  end

  // Registers; count is never touched by frame boundaries
  // count kept over SOF
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      serve_ctrl_reg <= 1'b0;
      serve_bulk_reg <= 1'b0;
      count_reg      <= COUNT_W'(`OHLC_COUNT_RST);
    end else begin
      serve_ctrl_reg <= serve_ctrl_next;
      serve_bulk_reg <= serve_bulk_next;
      count_reg      <= count_next;
    end
  end

  assign serve_ctrl_out = serve_ctrl_reg;
  assign serve_bulk_out = serve_bulk_reg;
  assign ctrl_count_out = count_reg;

endmodule : ohlc_np_arbiter

// ===== ohlc_pkg.sv
// Types shared by the list control block
package ohlc_pkg;

  // Frame phase of the list scheduler, one-hot
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h1,
    ST_PERIODIC = 3'h2,
    ST_NONPER   = 3'h4
  } ohlc_phase_t;

  // Control-to-bulk ratio field
  typedef logic [1:0] ohlc_ratio_t;

endpackage : ohlc_pkg
